// >>> cecb_bank.sv
// extended control register bank with privilege checked system register access
//
// Contract
// [R1] way limit field, zero disables borrowing, default two
// [R2] instruction partition reserves top n ways
// [R3] data partition reserves bottom n ways
// [R4] vmid filter flushes after 16 or 32
// [R5] splinter bit set stops splintered allocation
// [R6] contiguous hint ignored when disable bit set
// [R7] tlb prefetcher stops when disable bit set
// [R8] first level aggregation off when bit set
// [R9] all page aggregation off when bit set
// [R10] dcc 00 no data, 01 unique clean only
// [R11] dcc 10 and 11 evict-or-evict, scu default
// [R12] reads: el0 undefined, el1 trap on impl trap
// [R13] writes trap el2 then el3 enables
// [R14] two 64-bit opaque auxiliary registers
// [R15] evict sent only when snoop filter present
// [R16] reserved bits 50:48 read zero
`timescale 1ns/10ps
`default_nettype none
module cecb_bank #(
  parameter bit SCU_PRESENT = 1'b1,
  parameter int WAYS        = 8
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire cecb_pkg::cecb_req_s  i_req,
  input  wire cecb_pkg::cecb_ctx_s  i_ctx,
  input  wire logic                 i_vmid_alloc,
  output logic                      o_ack,
  output logic      [1:0]           o_resp,
  output logic      [1:0]           o_trap_el,
  output logic      [5:0]           o_trap_class,
  output logic      [63:0]          o_rdata,
  output logic                      o_vmid_flush,
  output cecb_pkg::cecb_ctl_s       o_ctl
);

  localparam logic [63:0] ECTL_RST = cecb_pkg::ECTL_RST_BASE |
    (64'(SCU_PRESENT ? cecb_pkg::DCC_RST_SCU : cecb_pkg::DCC_RST_NO_SCU) << cecb_pkg::DCC_LO);

  logic [63:0] aux3_ff;
  logic [63:0] aux4_ff;
  logic [63:0] ectl_ff;
  logic [5:0]  vmid_cnt_ff;
  logic        ok_wr;
  logic [1:0]  nxt_resp;
  logic [1:0]  nxt_trap_el;
  logic [63:0] nxt_rdata;
  logic [7:0]  imask;
  logic [7:0]  dmask;

  // access check; the checks run in a fixed order so the first failing one names the target
  always_comb begin
    nxt_resp    = cecb_pkg::RESP_OK;
    nxt_trap_el = 2'h0;
    if (i_req.el == cecb_pkg::CECB_EL0) begin
      nxt_resp = cecb_pkg::RESP_UNDEF; // see [R12]
    end else if (i_req.el == cecb_pkg::CECB_EL1 && i_ctx.el2_enabled && i_ctx.impl_reg_trap) begin
      nxt_resp    = cecb_pkg::RESP_TRAP; // see [R12]
      nxt_trap_el = cecb_pkg::TGT_EL2;
    end else if (i_req.write && i_req.el != cecb_pkg::CECB_EL3) begin
      if (i_ctx.el2_enabled && !i_ctx.hyp_aux_access_enable) begin
        nxt_resp    = cecb_pkg::RESP_TRAP; // see [R13]
        nxt_trap_el = cecb_pkg::TGT_EL2;
      end else if (!i_ctx.mon_aux_access_enable) begin
        nxt_resp    = cecb_pkg::RESP_TRAP; // see [R13]
        nxt_trap_el = cecb_pkg::TGT_EL3;
      end
    end
  end

  assign ok_wr = i_req.valid && i_req.write && (nxt_resp == cecb_pkg::RESP_OK);

  // read mux; the counter select gives the filter fill level for debug
  always_comb begin
    case (i_req.sel)
      cecb_pkg::SEL_AUX3: nxt_rdata = aux3_ff;
      cecb_pkg::SEL_AUX4: nxt_rdata = aux4_ff;
      cecb_pkg::SEL_ECTL: nxt_rdata = ectl_ff;
      default:            nxt_rdata = 64'(vmid_cnt_ff);
    endcase
    if (i_req.write || nxt_resp != cecb_pkg::RESP_OK) begin
      nxt_rdata = 64'h0; // nothing leaks on a refused access
    end
  end

  // auxiliary registers hold whatever software writes, no decoded effect
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      aux3_ff <= cecb_pkg::AUX_RST;
      aux4_ff <= cecb_pkg::AUX_RST;
    end else if (ok_wr) begin
      if (i_req.sel == cecb_pkg::SEL_AUX3) begin
        aux3_ff <= i_req.wdata; // see [R14]
      end
      if (i_req.sel == cecb_pkg::SEL_AUX4) begin
        aux4_ff <= i_req.wdata; // see [R14]
      end
    end
  end

  // extended register; reserved and undescribed bits masked off on write
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ectl_ff <= ECTL_RST; // see [R1]
    end else if (ok_wr && i_req.sel == cecb_pkg::SEL_ECTL) begin
      ectl_ff <= i_req.wdata & cecb_pkg::ECTL_WMASK; // see [R16]
    end
  end

  // access answer, one cycle after the request
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ack        <= 1'b0;
      o_resp       <= cecb_pkg::RESP_OK;
      o_trap_el    <= 2'h0;
      o_trap_class <= 6'h0;
      o_rdata      <= 64'h0;
    end else begin
      o_ack        <= i_req.valid;
      o_resp       <= i_req.valid ? nxt_resp : cecb_pkg::RESP_OK;
      o_trap_el    <= i_req.valid ? nxt_trap_el : 2'h0;
      o_trap_class <= (i_req.valid && nxt_resp == cecb_pkg::RESP_TRAP) ? cecb_pkg::TRAP_CLASS : 6'h0;
      o_rdata      <= i_req.valid ? nxt_rdata : 64'h0;
    end
  end

  // unique vmid allocation counter; flush pulses when the selected threshold is reached
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      vmid_cnt_ff  <= 6'h0;
      o_vmid_flush <= 1'b0;
    end else begin
      o_vmid_flush <= 1'b0;
      if (i_vmid_alloc) begin
        if (vmid_cnt_ff + 6'h1 >= (ectl_ff[cecb_pkg::VMID_BIT] ? cecb_pkg::VMID_THR_HI
                                                                : cecb_pkg::VMID_THR_LO)) begin
          vmid_cnt_ff  <= 6'h0; // see [R4]
          o_vmid_flush <= 1'b1;
        end else begin
          vmid_cnt_ff <= vmid_cnt_ff + 6'h1;
        end
      end
    end
  end

  cecb_way_mask #(
    .WAYS     (WAYS),
    .FROM_TOP (1'b1)
  ) u_imask (
    .i_count (ectl_ff[cecb_pkg::IPART_HI:cecb_pkg::IPART_LO]),
    .o_mask  (imask)
  );

  cecb_way_mask #(
    .WAYS     (WAYS),
    .FROM_TOP (1'b0)
  ) u_dmask (
    .i_count (ectl_ff[cecb_pkg::DPART_HI:cecb_pkg::DPART_LO]),
    .o_mask  (dmask)
  );

  // decoded controls registered so datapath sees a clean copy one cycle after a write
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ctl <= '0;
    end else begin
      o_ctl.way_borrowing_agent_en <= |ectl_ff[cecb_pkg::WAYLIM_HI:cecb_pkg::WAYLIM_LO]; // see [R1]
      o_ctl.borrow_way_limit       <= ectl_ff[cecb_pkg::WAYLIM_HI:cecb_pkg::WAYLIM_LO];  // see [R1]
      o_ctl.instr_only_ways        <= imask; // see [R2]
      o_ctl.data_only_ways         <= dmask; // see [R3]
      o_ctl.splinter_alloc_ok          <= !ectl_ff[cecb_pkg::SPLNT_BIT]; // see [R5]
      o_ctl.contig_hint_use            <= !ectl_ff[cecb_pkg::CHINT_BIT]; // see [R6]
      o_ctl.tlb_prefetch_en            <= !ectl_ff[cecb_pkg::TLBPF_BIT]; // see [R7]
      o_ctl.first_level_aggregation_en <= !ectl_ff[cecb_pkg::AGGL1_BIT] && !ectl_ff[cecb_pkg::AGG_BIT]; // see [R8]
      o_ctl.page_aggregation_en        <= !ectl_ff[cecb_pkg::AGG_BIT]; // see [R9]
      o_ctl.send_uc_data            <= |ectl_ff[cecb_pkg::DCC_HI:cecb_pkg::DCC_LO]; // see [R10]
      o_ctl.send_sc_data            <= &ectl_ff[cecb_pkg::DCC_HI:cecb_pkg::DCC_LO]; // see [R11]
      o_ctl.uc_write_evict_or_evict <= ectl_ff[cecb_pkg::DCC_HI]; // see [R11]
      o_ctl.send_evict              <= ectl_ff[cecb_pkg::SFP_BIT]; // see [R15]
    end
  end

endmodule : cecb_bank
`default_nettype wire

// >>> cecb_bank_sva.sv
// checker: access outcome, decode and flush assertions for the control bank
`timescale 1ns/10ps
`default_nettype none
module cecb_chk #(
  parameter bit SCU_PRESENT = 1'b1,
  parameter int WAYS        = 8
) (
  input wire logic                i_mclk,
  input wire logic                i_rst,
  input wire cecb_pkg::cecb_req_s i_req,
  input wire cecb_pkg::cecb_ctx_s i_ctx,
  input wire logic                i_vmid_alloc,
  input wire logic                o_ack,
  input wire logic [1:0]          o_resp,
  input wire logic [1:0]          o_trap_el,
  input wire logic [5:0]          o_trap_class,
  input wire logic [63:0]         o_rdata,
  input wire logic                o_vmid_flush,
  input wire cecb_pkg::cecb_ctl_s o_ctl
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // monitor-level access: never refused, so its effect is certain
  sequence el3_req;
    i_req.valid && i_req.el == cecb_pkg::CECB_EL3;
  endsequence
  // the decode shows two edges after the write is taken
  sequence ectl_wr;
    el3_req and (i_req.write && i_req.sel == cecb_pkg::SEL_ECTL);
  endsequence
  chk_ack_pulse:
    assert property (o_ack == $past(i_req.valid)) else $error("ack not one cycle after request");
  chk_el0_undef:
    assert property (i_req.valid && i_req.el == cecb_pkg::CECB_EL0 |=> o_resp == cecb_pkg::RESP_UNDEF)
      else $error("el0 access not undefined");
  chk_read_trap:
    assert property (i_req.valid && !i_req.write && i_req.el == cecb_pkg::CECB_EL1 && i_ctx.el2_enabled
      && i_ctx.impl_reg_trap |=> o_trap_el == cecb_pkg::TGT_EL2 && o_trap_class == cecb_pkg::TRAP_CLASS)
      else $error("el1 read not trapped to el2");
  chk_mon_trap:
    assert property (i_req.valid && i_req.write && i_req.el inside {cecb_pkg::CECB_EL1, cecb_pkg::CECB_EL2}
      && !i_ctx.el2_enabled && !i_ctx.mon_aux_access_enable |=> o_resp == cecb_pkg::RESP_TRAP
      && o_trap_el == cecb_pkg::TGT_EL3) else $error("write not trapped to el3");
  chk_el3_ok:
    assert property (el3_req |=> o_resp == cecb_pkg::RESP_OK && o_trap_el == 2'h0)
      else $error("el3 access refused");
  chk_rsv_zero:
    assert property (el3_req and (!i_req.write && i_req.sel == cecb_pkg::SEL_ECTL) |=> o_rdata[50:48] == 3'h0)
      else $error("reserved bits read nonzero");
  chk_way_masks:
    assert property (ectl_wr |-> ##2 o_ctl.instr_only_ways == ~(8'hff >> $past(i_req.wdata[60:58], 2))
      && o_ctl.data_only_ways == ~(8'hff << $past(i_req.wdata[57:55], 2))) else $error("way masks wrong");
  chk_flush_pulse:
    assert property (o_vmid_flush |-> $past(i_vmid_alloc) ##1 !o_vmid_flush)
      else $error("flush without allocation or too long");
endmodule : cecb_chk
bind cecb_bank cecb_chk #(.SCU_PRESENT(SCU_PRESENT), .WAYS(WAYS)) i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_req(i_req), .i_ctx(i_ctx), .i_vmid_alloc(i_vmid_alloc), .o_ack(o_ack), .o_resp(o_resp),
  .o_trap_el(o_trap_el), .o_trap_class(o_trap_class), .o_rdata(o_rdata), .o_vmid_flush(o_vmid_flush),
  .o_ctl(o_ctl));
`default_nettype wire

// >>> cecb_bank_tb_top.sv
// testbench: directed and random register traffic against a reference model
`timescale 1ns/10ps
`default_nettype none
module cecb_bank_tb_top;
  logic                i_mclk = 1'b0;
  logic                i_rst = 1'b1;
  cecb_pkg::cecb_req_s i_req = '0;
  cecb_pkg::cecb_ctx_s i_ctx = '0;
  logic                i_vmid_alloc = 1'b0;
  logic                o_ack, o_vmid_flush;
  logic [1:0]          o_resp, o_trap_el;
  logic [5:0]          o_trap_class;
  logic [63:0]         o_rdata, m_ectl;
  logic [63:0]         m_aux[2];
  cecb_pkg::cecb_ctl_s o_ctl;
  int                  num_errors = 0, num_checks = 0, cyc = 0, m_cnt = 0;

  cecb_bank i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_ctx(i_ctx), .i_vmid_alloc(i_vmid_alloc),
    .o_ack(o_ack), .o_resp(o_resp), .o_trap_el(o_trap_el), .o_trap_class(o_trap_class), .o_rdata(o_rdata),
    .o_vmid_flush(o_vmid_flush), .o_ctl(o_ctl));

  // clock, and a cycle ceiling so a hang still reaches the report
  initial forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : cmp

  // expected datapath controls for a given extended register value
  function automatic cecb_pkg::cecb_ctl_s ctl_of(input logic [63:0] e);
    return '{e[63:61] != 3'h0, e[63:61], ~(8'hff >> e[60:58]), ~(8'hff << e[57:55]), !e[53], !e[52], !e[51],
      !e[47] && !e[46], !e[46], e[45:44] != 2'h0, e[45:44] == 2'h3, e[45], e[42]};
  endfunction : ctl_of

  // one access: model decides outcome, then response and decode are compared
  task automatic acc(input logic wr, input logic [1:0] sel, input cecb_pkg::cecb_el_e el, input logic [63:0] wd,
                     input cecb_pkg::cecb_ctx_s cx);
    logic [1:0]  er, et;
    logic [63:0] ed;
    er = cecb_pkg::RESP_TRAP;
    et = 2'h0;
    ed = 64'h0;
    if (el == cecb_pkg::CECB_EL0) er = cecb_pkg::RESP_UNDEF;
    else if (el == cecb_pkg::CECB_EL1 && cx.el2_enabled && cx.impl_reg_trap) et = cecb_pkg::TGT_EL2;
    else if (el != cecb_pkg::CECB_EL3 && wr && cx.el2_enabled && !cx.hyp_aux_access_enable) et = cecb_pkg::TGT_EL2;
    else if (el != cecb_pkg::CECB_EL3 && wr && !cx.mon_aux_access_enable) et = cecb_pkg::TGT_EL3;
    else er = cecb_pkg::RESP_OK;
    // the count select reads back the allocation counter and ignores writes
    if (er == cecb_pkg::RESP_OK && !wr && sel == cecb_pkg::SEL_CNT) ed = 64'(m_cnt);
    else if (er == cecb_pkg::RESP_OK && !wr) ed = (sel == cecb_pkg::SEL_ECTL) ? m_ectl : m_aux[sel[0]];
    if (er == cecb_pkg::RESP_OK && wr && sel == cecb_pkg::SEL_ECTL) m_ectl = wd & cecb_pkg::ECTL_WMASK;
    else if (er == cecb_pkg::RESP_OK && wr && sel != cecb_pkg::SEL_CNT) m_aux[sel[0]] = wd;
    @(negedge i_mclk);
    i_ctx = cx;
    i_req = '{1'b1, wr, sel, el, wd};
    @(negedge i_mclk);
    i_req.valid = 1'b0;
    cmp(64'(o_ack), 64'h1, "ack");
    cmp(64'(o_resp), 64'(er), "resp");
    cmp(64'(o_trap_el), 64'(et), "trap level");
    cmp(64'(o_trap_class), (et != 2'h0) ? 64'(cecb_pkg::TRAP_CLASS) : 64'h0, "class");
    cmp(o_rdata, ed, "read data");
    @(negedge i_mclk);
    cmp(64'(o_ctl), 64'(ctl_of(m_ectl)), "controls");
  endtask : acc

  // random allocation pulses, flush expected after the selected threshold
  task automatic vmid(input int n);
    logic ef;
    ef = 1'b0;
    repeat (n + 1) begin
      @(negedge i_mclk);
      cmp(64'(o_vmid_flush), 64'(ef), "flush");
      i_vmid_alloc = (n-- > 0) && ($urandom_range(0, 3) != 0);
      m_cnt += i_vmid_alloc;
      ef = (m_cnt == (m_ectl[54] ? 32 : 16));
      if (ef) m_cnt = 0;
    end
  endtask : vmid

  // main sequence: reset values, field sweep, flush thresholds, random traffic
  initial begin
    void'($urandom(54));
    m_aux = '{64'h0, 64'h0};
    m_ectl = cecb_pkg::ECTL_RST_BASE | (64'(cecb_pkg::DCC_RST_SCU) << 44);
    repeat (5) @(negedge i_mclk);
    i_rst = 1'b0;
    for (int s = 0; s < 3; s++) acc(1'b0, 2'(s), cecb_pkg::CECB_EL3, 64'h0, '0);
    acc(1'b1, cecb_pkg::SEL_ECTL, cecb_pkg::CECB_EL3, '1, '0);
    acc(1'b0, cecb_pkg::SEL_ECTL, cecb_pkg::CECB_EL3, 64'h0, '0);
    for (int i = 0; i < 8; i++) acc(1'b1, cecb_pkg::SEL_ECTL, cecb_pkg::CECB_EL3,
      64'(i) * 64'h2480_0000_0000_0000 | 64'(i) << 44, '0);
    vmid(50);
    acc(1'b0, cecb_pkg::SEL_CNT, cecb_pkg::CECB_EL3, 64'h0, '0);
    acc(1'b1, cecb_pkg::SEL_ECTL, cecb_pkg::CECB_EL3, 64'h0040_0000_0000_0000, '0);
    vmid(90);
    acc(1'b0, cecb_pkg::SEL_CNT, cecb_pkg::CECB_EL3, 64'h0, '0);
    for (int k = 0; k < 300; k++) acc(1'(($urandom)), 2'($urandom_range(0, 2)),
      cecb_pkg::cecb_el_e'($urandom_range(0, 3)), {$urandom, $urandom},
      cecb_pkg::cecb_ctx_s'(4'($urandom)));
    end_of_test();
  end
endmodule : cecb_bank_tb_top
`default_nettype wire

// >>> cecb_pkg.sv
// package: field layout, reset values, access codes and types for the extended control bank
package cecb_pkg;

  // exception levels of the requester
  typedef enum logic [1:0] {
    CECB_EL0 = 2'h0,
    CECB_EL1 = 2'h1,
    CECB_EL2 = 2'h2,
    CECB_EL3 = 2'h3
  } cecb_el_e;

  // register select codes
  localparam logic [1:0] SEL_AUX3 = 2'h0;
  localparam logic [1:0] SEL_AUX4 = 2'h1;
  localparam logic [1:0] SEL_ECTL = 2'h2;
  localparam logic [1:0] SEL_CNT  = 2'h3;

  // access outcome codes
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_UNDEF = 2'h1;
  localparam logic [1:0] RESP_TRAP  = 2'h2;

  localparam logic [1:0] TGT_EL2 = 2'h2;
  localparam logic [1:0] TGT_EL3 = 2'h3;
  localparam logic [5:0] TRAP_CLASS = 6'h18;

  // extended control field positions
  localparam int WAYLIM_HI  = 63;
  localparam int WAYLIM_LO  = 61;
  localparam int IPART_HI   = 60;
  localparam int IPART_LO   = 58;
  localparam int DPART_HI   = 57;
  localparam int DPART_LO   = 55;
  localparam int VMID_BIT   = 54;
  localparam int SPLNT_BIT  = 53;
  localparam int CHINT_BIT  = 52;
  localparam int TLBPF_BIT  = 51;
  localparam int RSV_HI     = 50;
  localparam int RSV_LO     = 48;
  localparam int AGGL1_BIT  = 47;
  localparam int AGG_BIT    = 46;
  localparam int DCC_HI     = 45;
  localparam int DCC_LO     = 44;
  localparam int SFP_BIT    = 42;

  // writable bits of the extended register: 63:51, 47:44, 42
  localparam logic [63:0] ECTL_WMASK = 64'hfff8_f400_0000_0000;

  // reset values
  localparam logic [2:0]  WAYLIM_RST = 3'h2;
  localparam logic [1:0]  DCC_RST_NO_SCU = 2'h2;
  localparam logic [1:0]  DCC_RST_SCU    = 2'h3;
  localparam logic [63:0] ECTL_RST_BASE  = 64'h4000_0400_0000_0000;
  localparam logic [63:0] AUX_RST        = 64'h0;

  // filter flush thresholds
  localparam logic [5:0] VMID_THR_LO = 6'h10;
  localparam logic [5:0] VMID_THR_HI = 6'h20;

  // access request carried as one bundle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  sel;
    cecb_el_e    el;
    logic [63:0] wdata;
  } cecb_req_s;

  // security and hypervisor state that gates access
  typedef struct packed {
    logic el2_enabled;
    logic impl_reg_trap;
    logic hyp_aux_access_enable;
    logic mon_aux_access_enable;
  } cecb_ctx_s;

  // decoded controls to the cache and tlb datapaths
  typedef struct packed {
    logic       way_borrowing_agent_en;
    logic [2:0] borrow_way_limit;
    logic [7:0] instr_only_ways;
    logic [7:0] data_only_ways;
    logic       splinter_alloc_ok;
    logic       contig_hint_use;
    logic       tlb_prefetch_en;
    logic       first_level_aggregation_en;
    logic       page_aggregation_en;
    logic       send_uc_data;
    logic       send_sc_data;
    logic       uc_write_evict_or_evict;
    logic       send_evict;
  } cecb_ctl_s;

endpackage : cecb_pkg

// >>> cecb_way_mask.sv
// thermometer way mask: n ways counted from top or bottom
`timescale 1ns/10ps
`default_nettype none
module cecb_way_mask #(
  parameter int WAYS    = 8,
  parameter bit FROM_TOP = 1'b0
) (
  input  wire logic [2:0]      i_count,
  output logic      [WAYS-1:0] o_mask
);

  // one comparator per way; way index counted from the chosen end
  for (genvar w = 0; w < WAYS; w++) begin : g_way
    localparam int RANK = FROM_TOP ? (WAYS - 1 - w) : w;
    assign o_mask[w] = (32'(i_count) > RANK);
  end

endmodule : cecb_way_mask
`default_nettype wire
